// [design/fdd_form_decoder.sv]
// Form descriptor decoder with APB registers and tile list walker
//
// Overview of operation
// - Flag bit 0 reports some rectangle lies on the physical bitmap.
// - Flag bit 1 reports some rectangle lies on the virtual bitmap.
// - Flag bit 2 reports some rectangle lies on neither bitmap.
// - Flag bit 3 reports some rectangle is write inhibited.
// - Flag bit 4 reports a single rectangle; clear means several.
// - Flag bit 5 replicates the low pixel byte on writes.
// - Form mask AND operation mask selects the bits drawn.
// - Pixel reads return masked bits, zero elsewhere.
// - Kind bit 0 set marks physical fields invalid; rest ignored.
// - Kind bits 13-15 decode allowed pixel depths.
// - Kind bits 26-31 give the largest pixel count per transfer.
// - First descriptor word links the next; all ones ends the walk.
// - Rectangles on neither bitmap are accepted but never drawn.
// - Nothing is drawn when both masks are zero.
// - Write-inhibited rectangles may be read but never written.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module fdd_form_decoder #(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output fdd_pkg::fdd_mem_rd_t mem_rd_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   output fdd_pkg::fdd_pix_wr_t pix_wr_o
);
   import fdd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Byte-lane merge for APB writes
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Bit offset of a pixel from shifts and coordinates
   function automatic logic [31:0] pix_bitoff(input logic [15:0] x,
                                              input logic [15:0] y,
                                              input logic [4:0] bpp_sh,
                                              input logic [4:0] line_sh);
      logic [31:0] lin;
      lin = ({16'h0000, y} << line_sh) + {16'h0000, x};
      return lin << bpp_sh;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0] flags_q, fmask_q, opmask_q, kind_q;
   logic [31:0] pbase_q, vbase_q, tileptr_q;
   logic [4:0] pbpp_q, pline_q, vbpp_q, vline_q;
   logic [31:0] pixxy_q, pixdst_q, pixrd_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   fdd_walk_t walk_q;
   fdd_mem_rd_t mem_rd_q;
   fdd_pix_wr_t pix_wr_q;
   logic [31:0] cur_ptr_q, next_ptr_q, rect_flags_q;
   logic [CNT_W-1:0] rect_cnt_q;

   // APB decode
   logic acc, wr_acc, addr_ok;
   logic [7:0] reg_off;
   assign reg_off = 8'(paddr_i);
   assign acc = psel_i & penable_i & pready_q;
   assign wr_acc = acc & pwrite_i;

   // Write strobes per register
   function automatic logic hit(input logic [7:0] off);
      return wr_acc & (reg_off == off) & ~pslverr_q;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decoded form state

   // Combined draw mask
   logic [31:0] draw_mask;
   assign draw_mask = fmask_q & opmask_q;

   logic phys_valid;
   assign phys_valid = ~kind_q[FDD_DK_NOBOARD];

   logic [2:0] depth_code;
   logic [5:0] depth_set;
   assign depth_code = kind_q[FDD_DK_DEPTH_HI:FDD_DK_DEPTH_LO];
   always_comb begin
      depth_set = 6'h00;
      if (phys_valid) begin
         case (depth_code)
            FDD_DEPTH_C4: depth_set = FDD_SET_4;
            FDD_DEPTH_C248: depth_set = FDD_SET_248;
            FDD_DEPTH_C32: depth_set = FDD_SET_32;
            default: depth_set = 6'h00;
         endcase
      end
   end

   logic [5:0] max_xfer;
   assign max_xfer = phys_valid ? kind_q[FDD_DK_XFER_HI:0] : 6'h00;

   logic [4:0] summary;
   assign summary = {flags_q[FDD_FF_SINGLE], flags_q[FDD_FF_INHIB],
                     flags_q[FDD_FF_NONE], flags_q[FDD_FF_VIRT],
                     flags_q[FDD_FF_PHYS]};

   // Placement of the rectangle in hand
   logic at_rect, on_phys, on_virt, on_none, inhib, write_ok;
   assign at_rect = (walk_q == FDD_AT_RECT);
   assign on_phys = rect_flags_q[FDD_RF_PHYS];
   assign on_virt = rect_flags_q[FDD_RF_VIRT];
   assign on_none = rect_flags_q[FDD_RF_NONE] | ~(on_phys | on_virt);
   assign inhib = rect_flags_q[FDD_RF_INHIB];

   assign write_ok = at_rect & ~inhib & ~on_none & (draw_mask != 32'h0) &
                     (on_phys ? phys_valid : 1'b1);

   logic [31:0] bitoff, wr_addr, base_sel;
   assign base_sel = on_phys ? pbase_q : vbase_q;
   assign bitoff = on_phys ?
                   pix_bitoff(pixxy_q[15:0], pixxy_q[31:16], pbpp_q, pline_q) :
                   pix_bitoff(pixxy_q[15:0], pixxy_q[31:16], vbpp_q, vline_q);
   assign wr_addr = base_sel +
                    ((bitoff >> FDD_WORD_SHIFT) << FDD_BYTE_SHIFT);

   logic [31:0] src_val;
   assign src_val = flags_q[FDD_FF_REPL] ? {4{pwdata_i[7:0]}} : pwdata_i;

   // Status and decode views
   logic [31:0] status_v, decode_v;
   assign status_v = {rect_cnt_q, 7'h00, phys_valid, write_ok, inhib,
                      on_none & at_rect, on_virt, on_phys,
                      walk_q == FDD_DONE, at_rect,
                      walk_q != FDD_IDLE && walk_q != FDD_DONE};
   assign decode_v = {10'h000, summary, phys_valid,
                      2'b00, max_xfer, 2'b00, depth_set};

   ////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait cycle, then the access completes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel_i & penable_i & ~pready_q;
         pslverr_q <= psel_i & penable_i & ~pready_q & ~addr_ok;
      end
   end

   // Address map check and read mux
   logic [31:0] rd_mux;
   always_comb begin
      addr_ok = 1'b1;
      rd_mux = 32'h00000000;
      if (paddr_i[1:0] != 2'b00) begin
         addr_ok = 1'b0;
      end
      case (reg_off)
         FDD_OFF_FLAGS: rd_mux = flags_q;
         FDD_OFF_FMASK: rd_mux = fmask_q;
         FDD_OFF_OPMASK: rd_mux = opmask_q;
         FDD_OFF_KIND: rd_mux = kind_q;
         FDD_OFF_PBASE: rd_mux = pbase_q;
         FDD_OFF_PBPP: rd_mux = {27'h0, pbpp_q};
         FDD_OFF_PLINE: rd_mux = {27'h0, pline_q};
         FDD_OFF_VBASE: rd_mux = vbase_q;
         FDD_OFF_VBPP: rd_mux = {27'h0, vbpp_q};
         FDD_OFF_VLINE: rd_mux = {27'h0, vline_q};
         FDD_OFF_TILEPTR: rd_mux = tileptr_q;
         FDD_OFF_CTRL: rd_mux = 32'h00000000;
         FDD_OFF_STATUS: rd_mux = status_v;
         FDD_OFF_DECODE: rd_mux = decode_v;
         FDD_OFF_PIXXY: rd_mux = pixxy_q;
         FDD_OFF_PIXSRC: rd_mux = 32'h00000000;
         FDD_OFF_PIXDST: rd_mux = pixdst_q;
         FDD_OFF_PIXRD: rd_mux = pixrd_q;
         default: addr_ok = 1'b0;
      endcase
      if (!addr_ok) begin
         rd_mux = 32'h00000000;
      end
   end

   // Read data capture
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_q <= FDD_RST_WORD;
      end else if (psel_i & penable_i & ~pready_q & ~pwrite_i) begin
         prdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Form descriptor registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         flags_q <= FDD_RST_WORD;
         fmask_q <= FDD_RST_WORD;
         opmask_q <= FDD_RST_WORD;
         kind_q <= FDD_RST_WORD;
         pbase_q <= FDD_RST_WORD;
         vbase_q <= FDD_RST_WORD;
         tileptr_q <= FDD_RST_PTR;
      end else begin
         if (hit(FDD_OFF_FLAGS)) flags_q <= strb_merge(flags_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_FMASK)) fmask_q <= strb_merge(fmask_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_OPMASK)) opmask_q <= strb_merge(opmask_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_KIND)) kind_q <= strb_merge(kind_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_PBASE)) pbase_q <= strb_merge(pbase_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_VBASE)) vbase_q <= strb_merge(vbase_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_TILEPTR)) tileptr_q <= strb_merge(tileptr_q, pwdata_i, pstrb_i);
      end
   end

   // Bitmap shift registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pbpp_q <= 5'h00;
         pline_q <= 5'h00;
         vbpp_q <= 5'h00;
         vline_q <= 5'h00;
      end else begin
         if (hit(FDD_OFF_PBPP) & pstrb_i[0]) pbpp_q <= pwdata_i[4:0];
         if (hit(FDD_OFF_PLINE) & pstrb_i[0]) pline_q <= pwdata_i[4:0];
         if (hit(FDD_OFF_VBPP) & pstrb_i[0]) vbpp_q <= pwdata_i[4:0];
         if (hit(FDD_OFF_VLINE) & pstrb_i[0]) vline_q <= pwdata_i[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pixel coordinate, destination and read-back registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pixxy_q <= FDD_RST_WORD;
         pixdst_q <= FDD_RST_WORD;
         pixrd_q <= FDD_RST_WORD;
      end else begin
         if (hit(FDD_OFF_PIXXY)) pixxy_q <= strb_merge(pixxy_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_PIXDST)) pixdst_q <= strb_merge(pixdst_q, pwdata_i, pstrb_i);
         if (hit(FDD_OFF_PIXRD)) pixrd_q <= pwdata_i & fmask_q;
      end
   end

   // Pixel write issue, one-cycle strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pix_wr_q <= '0;
      end else begin
         pix_wr_q.we <= 1'b0;
         if (hit(FDD_OFF_PIXSRC) & write_ok) begin
            pix_wr_q.we <= 1'b1;
            pix_wr_q.to_virt <= ~on_phys;
            pix_wr_q.addr <= wr_addr;
            pix_wr_q.bit_pos <= bitoff[FDD_WORD_SHIFT-1:0];
            pix_wr_q.mask <= draw_mask;
            pix_wr_q.data <= (pixdst_q & ~draw_mask) | (src_val & draw_mask);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tile list walker
   logic start_cmd, step_cmd;
   assign start_cmd = hit(FDD_OFF_CTRL) & pstrb_i[0] & pwdata_i[FDD_CTRL_START];
   assign step_cmd = hit(FDD_OFF_CTRL) & pstrb_i[0] & pwdata_i[FDD_CTRL_STEP];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         walk_q <= FDD_IDLE;
         mem_rd_q <= '0;
         cur_ptr_q <= FDD_RST_PTR;
         next_ptr_q <= FDD_RST_PTR;
         rect_flags_q <= FDD_RST_WORD;
         rect_cnt_q <= '0;
      end else begin
         case (walk_q)
            FDD_IDLE, FDD_DONE: begin
               if (start_cmd) begin
                  rect_cnt_q <= '0;
                  rect_flags_q <= FDD_RST_WORD;
                  cur_ptr_q <= tileptr_q;
                  if (tileptr_q == FDD_LIST_END) begin
                     walk_q <= FDD_DONE;
                  end else begin
                     walk_q <= FDD_FETCH_NEXT;
                     mem_rd_q.req <= 1'b1;
                     mem_rd_q.addr <= tileptr_q;
                  end
               end
            end
            FDD_FETCH_NEXT: begin
               if (mem_rd_q.req & mem_ack_i) begin
                  next_ptr_q <= mem_rdata_i;
                  mem_rd_q.addr <= cur_ptr_q + FDD_WORD_BYTES;
                  walk_q <= FDD_FETCH_FLAGS;
               end
            end
            FDD_FETCH_FLAGS: begin
               if (mem_rd_q.req & mem_ack_i) begin
                  rect_flags_q <= mem_rdata_i;
                  mem_rd_q.req <= 1'b0;
                  rect_cnt_q <= rect_cnt_q + CNT_W'(1);
                  walk_q <= FDD_AT_RECT;
               end
            end
            FDD_AT_RECT: begin
               if (step_cmd) begin
                  if (next_ptr_q == FDD_LIST_END) begin
                     walk_q <= FDD_DONE;
                     rect_flags_q <= FDD_RST_WORD;
                  end else begin
                     cur_ptr_q <= next_ptr_q;
                     mem_rd_q.req <= 1'b1;
                     mem_rd_q.addr <= next_ptr_q;
                     walk_q <= FDD_FETCH_NEXT;
                  end
               end
            end
            default: begin
               walk_q <= FDD_IDLE;
               mem_rd_q.req <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign mem_rd_o = mem_rd_q;
   assign pix_wr_o = pix_wr_q;

endmodule

// [pkg/fdd_pkg.sv]
// Package for the form descriptor decoder: offsets, fields, types
package fdd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] FDD_OFF_FLAGS = 8'h00;
   localparam logic [7:0] FDD_OFF_FMASK = 8'h04;
   localparam logic [7:0] FDD_OFF_OPMASK = 8'h08;
   localparam logic [7:0] FDD_OFF_KIND = 8'h0C;
   localparam logic [7:0] FDD_OFF_PBASE = 8'h10;
   localparam logic [7:0] FDD_OFF_PBPP = 8'h14;
   localparam logic [7:0] FDD_OFF_PLINE = 8'h18;
   localparam logic [7:0] FDD_OFF_VBASE = 8'h1C;
   localparam logic [7:0] FDD_OFF_VBPP = 8'h20;
   localparam logic [7:0] FDD_OFF_VLINE = 8'h24;
   localparam logic [7:0] FDD_OFF_TILEPTR = 8'h28;
   localparam logic [7:0] FDD_OFF_CTRL = 8'h2C;
   localparam logic [7:0] FDD_OFF_STATUS = 8'h30;
   localparam logic [7:0] FDD_OFF_DECODE = 8'h34;
   localparam logic [7:0] FDD_OFF_PIXXY = 8'h38;
   localparam logic [7:0] FDD_OFF_PIXSRC = 8'h3C;
   localparam logic [7:0] FDD_OFF_PIXDST = 8'h40;
   localparam logic [7:0] FDD_OFF_PIXRD = 8'h44;

   ////////////////////////////////////////////////////////////////////////
   // Form flag fields (bit 0 is the most significant bit of the word)
   localparam int FDD_FF_PHYS = 31;
   localparam int FDD_FF_VIRT = 30;
   localparam int FDD_FF_NONE = 29;
   localparam int FDD_FF_INHIB = 28;
   localparam int FDD_FF_SINGLE = 27;
   localparam int FDD_FF_REPL = 26;

   // Rectangle flag fields
   localparam int FDD_RF_PHYS = 31;
   localparam int FDD_RF_VIRT = 30;
   localparam int FDD_RF_NONE = 29;
   localparam int FDD_RF_INHIB = 28;

   // Display kind word fields
   localparam int FDD_DK_NOBOARD = 31;
   localparam int FDD_DK_DEPTH_HI = 18;
   localparam int FDD_DK_DEPTH_LO = 16;
   localparam int FDD_DK_XFER_HI = 5;

   // Depth codes and the set of allowed depths (bit i means 2**i bits)
   localparam logic [2:0] FDD_DEPTH_C4 = 3'h2;
   localparam logic [2:0] FDD_DEPTH_C248 = 3'h3;
   localparam logic [2:0] FDD_DEPTH_C32 = 3'h5;
   localparam logic [5:0] FDD_SET_4 = 6'h04;
   localparam logic [5:0] FDD_SET_248 = 6'h0E;
   localparam logic [5:0] FDD_SET_32 = 6'h20;

   // Control bits
   localparam int FDD_CTRL_START = 0;
   localparam int FDD_CTRL_STEP = 1;

   // Descriptor layout
   localparam logic [31:0] FDD_LIST_END = 32'hFFFFFFFF;
   localparam logic [31:0] FDD_WORD_BYTES = 32'h00000004;
   localparam int FDD_WORD_SHIFT = 5;
   localparam int FDD_BYTE_SHIFT = 2;

   // Reset values
   localparam logic [31:0] FDD_RST_WORD = 32'h00000000;
   localparam logic [31:0] FDD_RST_PTR = 32'hFFFFFFFF;

   ////////////////////////////////////////////////////////////////////////
   // Walk states
   typedef enum logic [2:0] {
      FDD_IDLE = 3'b000,
      FDD_FETCH_NEXT = 3'b001,
      FDD_FETCH_FLAGS = 3'b010,
      FDD_AT_RECT = 3'b011,
      FDD_DONE = 3'b100
   } fdd_walk_t;

   // Pixel write request to the bitmap memory
   typedef struct packed {
      logic we;
      logic to_virt;
      logic [31:0] addr;
      logic [4:0] bit_pos;
      logic [31:0] data;
      logic [31:0] mask;
   } fdd_pix_wr_t;

   // Descriptor fetch request
   typedef struct packed {
      logic req;
      logic [31:0] addr;
   } fdd_mem_rd_t;

endpackage

// [verification/fdd_form_decoder_sva.sv]
// Checker for the form descriptor decoder ports
`timescale 1ns/1ns
module fdd_form_decoder_sva
   import fdd_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire fdd_pkg::fdd_mem_rd_t mem_rd_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i,
   input wire fdd_pkg::fdd_pix_wr_t pix_wr_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Source pixel write completing on the bus
   logic src_wr;
   assign src_wr = psel_i && penable_i && pready_o && pwrite_i
                   && paddr_i[7:0] == FDD_OFF_PIXSRC;

   ////////////////////////////////////////////////////////////////////////
   // Bus answer timing and errors
   AST_RDY_WAIT:
      assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("pready late after first access cycle");
   AST_RDY_ONE:
      assert property (pready_o |-> psel_i && penable_i ##1 !pready_o)
      else $error("pready outside access or too long");
   AST_ERR_ALIGN:
      assert property (psel_i && penable_i && pready_o
                       && paddr_i[1:0] != 2'h0 |-> pslverr_o)
      else $error("misaligned access without error");
   AST_ERR_RDZERO:
      assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("failed read returned data");

   ////////////////////////////////////////////////////////////////////////
   // Descriptor fetch
   AST_REQ_HOLD:
      assert property (mem_rd_o.req && !mem_ack_i
                       |=> mem_rd_o.req && $stable(mem_rd_o.addr))
      else $error("fetch request dropped or moved before ack");
   AST_FLAGS_WORD:
      assert property (mem_rd_o.req && mem_ack_i |=> !mem_rd_o.req
                       || mem_rd_o.addr == $past(mem_rd_o.addr) + 32'h4)
      else $error("second descriptor word not at next word");

   ////////////////////////////////////////////////////////////////////////
   // Pixel writes
   AST_WE_CAUSE:
      assert property (pix_wr_o.we |-> $past(src_wr))
      else $error("pixel write without source write");
   AST_MASK_NZ:
      assert property (pix_wr_o.we |-> pix_wr_o.mask != 32'h0)
      else $error("pixel write with empty mask");
   AST_WE_PULSE:
      assert property (pix_wr_o.we |=> !pix_wr_o.we)
      else $error("pixel write strobe longer than a cycle");
endmodule

bind fdd_form_decoder fdd_form_decoder_sva #(
   .ADDR_W(ADDR_W),
   .CNT_W(CNT_W)
) u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_rd_o(mem_rd_o),
   .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .pix_wr_o(pix_wr_o)
);

// [verification/tb_form_descriptor_decoder.sv]
// Self-checking bench for the form descriptor decoder
`timescale 1ns/1ns
module tb_form_descriptor_decoder;
   import fdd_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, mem_ack_i = 1'b0, e;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, slow_q = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, mem_rdata_i = 32'h0, prdata_o, r;
   logic [3:0] pstrb_i = 4'hF;
   logic [2:0] dly_q = 3'h0;
   logic pready_o, pslverr_o;
   fdd_mem_rd_t mem_rd_o;
   fdd_pix_wr_t pix_wr_o, last_wr;
   logic [31:0] dmem [0:1023];
   logic [5:0] dset;
   int num_errors = 0, n_compared = 0, we_cnt = 0, i;

   always #4 clk_i = ~clk_i;

   fdd_form_decoder u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_rd_o(mem_rd_o),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .pix_wr_o(pix_wr_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Descriptor memory, fast and slow answers in turn
   always @(posedge clk_i) begin
      if (mem_rd_o.req === 1'b1 && !mem_ack_i && dly_q == 3'h0) begin
         mem_ack_i <= 1'b1;
         mem_rdata_i <= dmem[mem_rd_o.addr[11:2]];
         dly_q <= slow_q ? 3'h3 : 3'h0;
         slow_q <= ~slow_q;
      end else begin
         mem_ack_i <= 1'b0;
         mem_rdata_i <= ~mem_rdata_i; // No stale word between answers
         if (mem_rd_o.req === 1'b1 && dly_q != 3'h0) dly_q <= dly_q - 3'h1;
      end
   end

   // Pixel write monitor
   always @(posedge clk_i) begin
      if (pix_wr_o.we === 1'b1) begin
         we_cnt <= we_cnt + 1;
         last_wr <= pix_wr_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Verdict and comparison helpers
   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic limit(input int n, input int max);
      if (n >= max) begin
         num_errors++;
         finish_test();
      end
   endtask

   // One bus transfer, result left in r and e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      r = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
      limit(n, 20);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdm(input logic [7:0] a, input logic [31:0] m, exp);
      apb(1'b0, a, 32'h0);
      chk(r & m, exp);
   endtask

   // Pixel source write and its outcome
   task automatic pix(input int ew, input logic [31:0] ea, ed, input logic ev);
      int c;
      c = we_cnt;
      wr(FDD_OFF_PIXSRC, 32'h12345678);
      @(posedge clk_i);
      chk(32'(we_cnt - c), 32'(ew));
      if (ew != 0) begin
         chk(last_wr.addr, ea);
         chk(last_wr.data, ed);
         chk({26'h0, last_wr.to_virt, last_wr.bit_pos}, {26'h0, ev, 5'h10});
         chk(last_wr.mask, 32'h0000FF0F);
      end
   endtask

   // Control write, then poll until the walker settles
   task automatic walk(input logic [31:0] ctl, m, exp);
      int n;
      wr(FDD_OFF_CTRL, ctl);
      n = 0;
      do begin
         apb(1'b0, FDD_OFF_STATUS, 32'h0);
         n++;
      end while (r[2:1] === 2'b00 && n < 40);
      limit(n, 40);
      chk(r & m, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      for (i = 0; i < 1024; i++) dmem[i] = 32'h0;
      dmem[64] = 32'h00000200;
      dmem[65] = 32'h80000000;
      dmem[128] = 32'h00000300;
      dmem[129] = 32'h50000000;
      dmem[192] = 32'h00000400;
      dmem[193] = 32'h20000000;
      dmem[256] = 32'hFFFFFFFF;
      dmem[257] = 32'h40000000;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rdm(FDD_OFF_TILEPTR, 32'hFFFFFFFF, FDD_RST_PTR);
      rdm(FDD_OFF_FLAGS, 32'hFFFFFFFF, 32'h0);
      apb(1'b0, 8'h48, 32'h0);
      chk({r[30:0], e}, 32'h1);
      apb(1'b1, 8'h06, 32'h0);
      chk({31'h0, e}, 32'h1);
      for (i = 0; i < 5; i++) begin
         wr(FDD_OFF_FLAGS, 32'h80000000 >> i);
         rdm(FDD_OFF_DECODE, 32'h3E0000, 32'h20000 << i);
      end
      wr(FDD_OFF_FLAGS, 32'h0);
      for (i = 0; i < 8; i++) begin
         dset = (i == 2) ? 6'h04 : (i == 3) ? 6'h0E : (i == 5) ? 6'h20 : 6'h00;
         wr(FDD_OFF_KIND, {13'h0, i[2:0], 10'h0, 6'o40});
         rdm(FDD_OFF_DECODE, 32'h00013F3F, {15'h0, 9'h120, 2'h0, dset});
      end
      wr(FDD_OFF_KIND, 32'h00030008);
      rdm(FDD_OFF_DECODE, 32'h00013F3F, 32'h0001080E);
      wr(FDD_OFF_KIND, 32'h80050008);
      rdm(FDD_OFF_DECODE, 32'h00013F3F, 32'h0);
      wr(FDD_OFF_FMASK, 32'h0000FFFF);
      wr(FDD_OFF_OPMASK, 32'h0000FF0F);
      wr(FDD_OFF_PBASE, 32'h00002000);
      wr(FDD_OFF_VBASE, 32'h00001000);
      wr(FDD_OFF_PBPP, 32'h4);
      wr(FDD_OFF_PLINE, 32'h4);
      wr(FDD_OFF_VBPP, 32'h4);
      wr(FDD_OFF_VLINE, 32'h4);
      wr(FDD_OFF_PIXXY, 32'h00020005);
      wr(FDD_OFF_PIXDST, 32'hAAAAAAAA);
      wr(FDD_OFF_PIXRD, 32'hDEADBEEF);
      rdm(FDD_OFF_PIXRD, 32'hFFFFFFFF, 32'h0000BEEF);
      wr(FDD_OFF_TILEPTR, 32'h00000100);
      walk(32'h1, 32'hFFFF007E, 32'h0001000A);
      pix(0, 32'h0, 32'h0, 1'b0);
      wr(FDD_OFF_KIND, 32'h0);
      pix(1, 32'h00002048, 32'hAAAA56A8, 1'b0);
      walk(32'h2, 32'hFFFF007E, 32'h00020052);
      pix(0, 32'h0, 32'h0, 1'b0);
      walk(32'h2, 32'hFFFF007E, 32'h00030022);
      pix(0, 32'h0, 32'h0, 1'b0);
      walk(32'h2, 32'hFFFF007E, 32'h00040012);
      pix(1, 32'h00001048, 32'hAAAA56A8, 1'b1);
      wr(FDD_OFF_FLAGS, 32'h04000000);
      pix(1, 32'h00001048, 32'hAAAA78A8, 1'b1);
      wr(FDD_OFF_OPMASK, 32'h0);
      wr(FDD_OFF_FMASK, 32'h0);
      pix(0, 32'h0, 32'h0, 1'b0);
      walk(32'h2, 32'h00000006, 32'h00000004);
      finish_test();
   end
endmodule
